/* design/ocb_option_bank.v */
`timescale 1ns/100ps
`include "ocb_consts.vh"
// What this block does
// - display bit moves bus pins to panel
// - rtc reconfiguration only with permission bit
// - debug disable hands pins to serial two
// - fuse option bits: erased clears, match sets
// - reset-output disable makes pin irq bit 6
// - clock-output disable makes pin irq bit 0
// - isolation bit low isolates rtc on lowvolt
// - second quad port enable remaps pulse pins
// - adc load bit gates fuse channel field
// - detector load bit gates fuse detector config
// - osc load bit gates fuse stable time
// - unlock needs 01, 10, 11 sequence
// - open field: 00 relocks, others ignored
// - pll: any unlock write relocks
// - pll top bits writable only when open
// - stable time defaults 3ff when erased
// - count stable time in slow ticks
// - count pll lock time in fast ticks
// - reset filter defaults 0d when erased
// - detector filter enable cleared when erased
// - detector filter value zero when erased
// - user-mode access ignored with transfer error
module ocb_option_bank (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        warmRstReq,
  input  wire [7:0]  busAddr,
  input  wire        busWr,
  input  wire        busRd,
  input  wire        busSuper,
  input  wire [15:0] busWdata,
  output reg  [15:0] busRdata_q,
  output reg         busErr_q,
  input  wire        fuseReady,
  input  wire        fuseCustErased,
  input  wire [5:0]  fuseCustMatch,
  input  wire        fuseOscErased,
  input  wire [11:0] fuseOscValue,
  input  wire        fuseRstfErased,
  input  wire [7:0]  fuseRstfValue,
  input  wire        fuseDetfErased,
  input  wire        fuseDetfEnable,
  input  wire [7:0]  fuseDetfValue,
  input  wire        fuseAdcErased,
  input  wire [7:0]  fuseAdcValue,
  input  wire        rtcDirReq,
  input  wire        lowVoltPin,
  input  wire        oscEnable,
  input  wire        slowOscTick,
  input  wire        pllEnable,
  input  wire        fastOscTick,
  output wire        display_iface_enable,
  output wire        debug_prog_disable,
  output wire        reset_out_pin_disable,
  output wire        clock_out_pin_disable,
  output wire        second_quad_port_enable,
  output wire        detector_cfg_fuse_load,
  output reg         rtcReconfigAllow_q,
  output reg         rtcIsolate_q,
  output reg  [7:0]  adc_channel_disable_field,
  output wire        oscGateOpen,
  output wire        pllGateOpen,
  output reg         fuseLoaded_q
);
  reg  [9:0]  cust_q;
  reg  [1:0]  custUnlk_q;
  reg  [11:0] oscStable_q;
  reg  [1:0]  oscUnlk_q;
  reg  [15:0] pll_lock_count_q;
  reg  [1:0]  pllUnlk_q;
  reg  [7:0]  reset_filter_value_q;
  reg  [1:0]  rstfUnlk_q;
  reg  [7:0]  detector_filter_value_q;
  reg         detector_filter_enable_q;
  reg  [1:0]  detfUnlk_q;
  reg         lowVoltMeta_q;
  reg         lowVoltSync_q;
  reg  [15:0] rdMux;
  reg  [9:0]  fuseCust;
  wire        wrOk;
  wire        rdOk;
  wire [1:0]  wUnlk;
  wire [15:0] oscGateOpenW;
  wire        oscGateW;
  wire        pllGateW;
  wire [2:0]  regSel;

  localparam [2:0] idxCust = 3'h0;
  localparam [2:0] idxOsc  = 3'h1;
  localparam [2:0] idxPll  = 3'h2;
  localparam [2:0] idxRstf = 3'h3;
  localparam [2:0] idxDetf = 3'h4;
  localparam [2:0] idxNone = 3'h7;

  // next unlock state for a sequence register after a write
  function [1:0] unlockNext;
    input [1:0] cur;
    input [1:0] wr;
    begin
      if (cur == `OCB_UNLK_OPEN)
        unlockNext = (wr == `OCB_UNLK_IDLE) ? `OCB_UNLK_IDLE : `OCB_UNLK_OPEN;
      else if (cur == `OCB_UNLK_IDLE && wr == `OCB_UNLK_ONE)
        unlockNext = `OCB_UNLK_ONE;
      else if (cur == `OCB_UNLK_ONE && wr == `OCB_UNLK_TWO)
        unlockNext = `OCB_UNLK_TWO;
      else if (cur == `OCB_UNLK_TWO && wr == `OCB_UNLK_OPEN)
        unlockNext = `OCB_UNLK_OPEN;
      else if (wr == `OCB_UNLK_ONE)
        unlockNext = `OCB_UNLK_ONE;
      else
        unlockNext = `OCB_UNLK_IDLE;
    end
  endfunction

  // one offset decode shared by read mux and write path
  function [2:0] regIndex;
    input [7:0] addr;
    begin
      case (addr)
        `OCB_OFS_CUST: regIndex = idxCust;
        `OCB_OFS_OSC:  regIndex = idxOsc;
        `OCB_OFS_PLL:  regIndex = idxPll;
        `OCB_OFS_RSTF: regIndex = idxRstf;
        `OCB_OFS_DETF: regIndex = idxDetf;
        default:       regIndex = idxNone;
      endcase
    end
  endfunction

  // a write is taken only from supervisor mode
  assign wrOk  = busWr & busSuper;
  assign rdOk  = busRd & busSuper;
  assign wUnlk = busWdata[`OCB_UNLK_HI:`OCB_UNLK_LO];
  assign regSel = regIndex(busAddr);

  assign display_iface_enable    = cust_q[`OCB_CUST_DISP];
  assign debug_prog_disable      = cust_q[`OCB_CUST_DBGDIS];
  assign reset_out_pin_disable   = cust_q[`OCB_CUST_RSTODIS];
  assign clock_out_pin_disable   = cust_q[`OCB_CUST_CLKODIS];
  assign second_quad_port_enable = cust_q[`OCB_CUST_QSPI2];
  assign detector_cfg_fuse_load  = cust_q[`OCB_CUST_DETLD];
  assign oscGateOpen             = oscGateW;
  assign pllGateOpen             = pllGateW;
  assign oscGateOpenW            = {4'h0, oscStable_q};

  // option bits from fuse: erased area clears, matched content sets
  always @* begin
    fuseCust = `OCB_RST_CUST;
    if (!fuseCustErased) begin
      fuseCust[`OCB_CUST_DBGDIS]  = fuseCustMatch[0];
      fuseCust[`OCB_CUST_RSTODIS] = fuseCustMatch[1];
      fuseCust[`OCB_CUST_CLKODIS] = fuseCustMatch[2];
      fuseCust[`OCB_CUST_ADCLD]   = fuseCustMatch[3];
      fuseCust[`OCB_CUST_DETLD]   = fuseCustMatch[4];
      fuseCust[`OCB_CUST_OSCLD]   = fuseCustMatch[5];
    end
  end

  always @* begin
    case (regSel)
      idxCust: rdMux = {custUnlk_q, 4'h0, cust_q};
      idxOsc:  rdMux = {oscUnlk_q, 2'h0, oscStable_q};
      idxPll:  rdMux = pll_lock_count_q;
      idxRstf: rdMux = {rstfUnlk_q, 6'h00, reset_filter_value_q};
      idxDetf: rdMux = {detfUnlk_q, 5'h00, detector_filter_enable_q,
                        detector_filter_value_q};
      default: rdMux = 16'h0000;
    endcase
  end

  // bus answer one cycle after the strobe
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdata_q <= 16'h0000;
      busErr_q   <= 1'b0;
    end else begin
      busRdata_q <= rdOk ? rdMux : 16'h0000;
      busErr_q   <= (busWr | busRd) & ~busSuper;
    end
  end

  // lowvolt event comes from the analog side
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowVoltMeta_q      <= 1'b0;
      lowVoltSync_q      <= 1'b0;
      rtcIsolate_q       <= 1'b0;
      rtcReconfigAllow_q <= 1'b0;
    end else begin
      lowVoltMeta_q      <= lowVoltPin;
      lowVoltSync_q      <= lowVoltMeta_q;
      rtcIsolate_q       <= lowVoltSync_q & ~cust_q[`OCB_CUST_RTCISO];
      rtcReconfigAllow_q <= rtcDirReq & cust_q[`OCB_CUST_RTCPERM];
    end
  end

  // rst_n is the power-on reset; fuse values arrive once after its release
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuseLoaded_q              <= 1'b0;
      cust_q                    <= `OCB_RST_CUST;
      custUnlk_q                <= `OCB_UNLK_IDLE;
      oscStable_q               <= `OCB_RST_OSC;
      oscUnlk_q                 <= `OCB_UNLK_IDLE;
      pll_lock_count_q          <= `OCB_RST_PLL;
      pllUnlk_q                 <= `OCB_UNLK_IDLE;
      reset_filter_value_q      <= `OCB_RST_RSTF;
      rstfUnlk_q                <= `OCB_UNLK_IDLE;
      detector_filter_value_q   <= `OCB_RST_DETF;
      detector_filter_enable_q  <= 1'b0;
      detfUnlk_q                <= `OCB_UNLK_IDLE;
      adc_channel_disable_field <= `OCB_RST_ADC;
    end else if (!fuseLoaded_q) begin
      // bus writes before the load are dropped; values come from fuse
      if (fuseReady) begin
        fuseLoaded_q <= 1'b1;
        cust_q       <= fuseCust;
        if (fuseCust[`OCB_CUST_OSCLD] && !fuseOscErased)
          oscStable_q <= fuseOscValue;
        else
          oscStable_q <= `OCB_RST_OSC;
        if (!fuseRstfErased)
          reset_filter_value_q <= fuseRstfValue;
        else
          reset_filter_value_q <= `OCB_RST_RSTF;
        if (fuseCust[`OCB_CUST_DETLD] && !fuseDetfErased) begin
          detector_filter_value_q  <= fuseDetfValue;
          detector_filter_enable_q <= fuseDetfEnable;
        end else begin
          detector_filter_value_q  <= `OCB_RST_DETF;
          detector_filter_enable_q <= 1'b0;
        end
        if (fuseCust[`OCB_CUST_ADCLD] && !fuseAdcErased)
          adc_channel_disable_field <= fuseAdcValue;
        else
          adc_channel_disable_field <= `OCB_RST_ADC;
      end
    end else if (warmRstReq) begin
      // other resets relock but keep software values
      custUnlk_q <= `OCB_UNLK_IDLE;
      oscUnlk_q  <= `OCB_UNLK_IDLE;
      pllUnlk_q  <= `OCB_UNLK_IDLE;
      rstfUnlk_q <= `OCB_UNLK_IDLE;
      detfUnlk_q <= `OCB_UNLK_IDLE;
    end else if (wrOk) begin
      case (regSel)
        idxCust: begin
          custUnlk_q <= unlockNext(custUnlk_q, wUnlk);
          if (custUnlk_q == `OCB_UNLK_OPEN)
            cust_q <= (cust_q & ~`OCB_CUST_WMASK)
                      | (busWdata[9:0] & `OCB_CUST_WMASK);
        end
        idxOsc: begin
          oscUnlk_q <= unlockNext(oscUnlk_q, wUnlk);
          if (oscUnlk_q == `OCB_UNLK_OPEN)
            oscStable_q <= busWdata[11:0];
        end
        idxPll: begin
          // field shares bits 15:14; when open the write loads the count
          if (pllUnlk_q == `OCB_UNLK_OPEN) begin
            pll_lock_count_q <= busWdata;
            pllUnlk_q        <= `OCB_UNLK_IDLE;
          end else begin
            pllUnlk_q <= unlockNext(pllUnlk_q, wUnlk);
          end
        end
        idxRstf: begin
          rstfUnlk_q <= unlockNext(rstfUnlk_q, wUnlk);
          if (rstfUnlk_q == `OCB_UNLK_OPEN)
            reset_filter_value_q <= busWdata[7:0];
        end
        idxDetf: begin
          detfUnlk_q <= unlockNext(detfUnlk_q, wUnlk);
          if (detfUnlk_q == `OCB_UNLK_OPEN) begin
            detector_filter_value_q  <= busWdata[7:0];
            detector_filter_enable_q <= busWdata[`OCB_DETF_EN];
          end
        end
        default: begin
          cust_q <= cust_q;
        end
      endcase
    end
  end

  ocb_gate_timer oscTimer (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .enable     (oscEnable),
    .tickPin    (slowOscTick),
    .limit      (oscGateOpenW),
    .gateOpen_q (oscGateW)
  );

  ocb_gate_timer pllTimer (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .enable     (pllEnable),
    .tickPin    (fastOscTick),
    .limit      (pll_lock_count_q),
    .gateOpen_q (pllGateW)
  );
endmodule

/* design/ocb_consts.vh */
`ifndef OCB_CONSTS_VH
`define OCB_CONSTS_VH

// byte offsets of the halfword registers
`define OCB_OFS_CUST      8'h1E
`define OCB_OFS_OSC       8'h20
`define OCB_OFS_PLL       8'h22
`define OCB_OFS_RSTF      8'h24
`define OCB_OFS_DETF      8'h26

// unlock field position and codes
`define OCB_UNLK_HI       15
`define OCB_UNLK_LO       14
`define OCB_UNLK_IDLE     2'h0
`define OCB_UNLK_ONE      2'h1
`define OCB_UNLK_TWO      2'h2
`define OCB_UNLK_OPEN     2'h3

// customer option register bits
`define OCB_CUST_DISP     0
`define OCB_CUST_RTCPERM  1
`define OCB_CUST_DBGDIS   2
`define OCB_CUST_RSTODIS  3
`define OCB_CUST_CLKODIS  4
`define OCB_CUST_RTCISO   5
`define OCB_CUST_QSPI2    6
`define OCB_CUST_ADCLD    7
`define OCB_CUST_DETLD    8
`define OCB_CUST_OSCLD    9
// software-writable bits of the customer register
`define OCB_CUST_WMASK    10'h07F

// detector filter register
`define OCB_DETF_EN       8

// power-on values; all but pll are also fallbacks for an erased fuse area
`define OCB_RST_OSC       12'h3FF
`define OCB_RST_RSTF      8'h0D
`define OCB_RST_DETF      8'h00
`define OCB_RST_PLL       16'h0000
`define OCB_RST_CUST      10'h000
`define OCB_RST_ADC       8'h00

`endif

/* design/ocb_gate_timer.v */
`timescale 1ns/100ps
module ocb_gate_timer (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        enable,
  input  wire        tickPin,
  input  wire [15:0] limit,
  output reg         gateOpen_q
);
  reg        tickMeta_q;
  reg        tickSync_q;
  reg        tickLast_q;
  reg [15:0] count_q;
  wire       tickEdge;

  // tick source runs on its own oscillator; must be slower than core_clk / 2
  assign tickEdge = tickSync_q & ~tickLast_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickMeta_q <= 1'b0;
      tickSync_q <= 1'b0;
      tickLast_q <= 1'b0;
      count_q    <= 16'h0000;
      gateOpen_q <= 1'b0;
    end else begin
      tickMeta_q <= tickPin;
      tickSync_q <= tickMeta_q;
      tickLast_q <= tickSync_q;
      if (!enable) begin
        count_q    <= 16'h0000;
        gateOpen_q <= 1'b0;
      end else if (!gateOpen_q) begin
        if (count_q >= limit) begin
          gateOpen_q <= 1'b1;
        end else if (tickEdge) begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end
endmodule

/* test/ocb_option_bank_props.sv */
`timescale 1ns/100ps
module ocb_option_bank_props (
  input wire        core_clk,
  input wire        rst_n,
  input wire        warmRstReq,
  input wire        busWr,
  input wire        busRd,
  input wire        busSuper,
  input wire [15:0] busRdata_q,
  input wire        busErr_q,
  input wire        rtcDirReq,
  input wire        rtcReconfigAllow_q,
  input wire        lowVoltPin,
  input wire        rtcIsolate_q,
  input wire        oscEnable,
  input wire        oscGateOpen,
  input wire        pllEnable,
  input wire        pllGateOpen,
  input wire        fuseLoaded_q,
  input wire        display_iface_enable,
  input wire        second_quad_port_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_user_err: assert property ((busWr || busRd) && !busSuper |=> busErr_q)
    else $error("user access gave no error");
  a_err_cause: assert property (busErr_q |-> $past(!busSuper && (busWr || busRd)))
    else $error("error without user access");
  a_super_ok: assert property ((busWr || busRd) && busSuper |=> !busErr_q)
    else $error("supervisor access gave error");
  a_rdata_idle: assert property (!(busRd && busSuper) |=> busRdata_q == 16'h0000)
    else $error("read data without supervisor read");
  a_rtc_permit: assert property (rtcReconfigAllow_q |-> $past(rtcDirReq))
    else $error("rtc reconfigure without request");
  a_iso_lowvolt: assert property (rtcIsolate_q |-> $past(lowVoltPin, 3))
    else $error("rtc isolated without low voltage");
  a_osc_gate: assert property (!oscEnable |=> !oscGateOpen)
    else $error("osc gate open while disabled");
  a_pll_gate: assert property (!pllEnable |=> !pllGateOpen)
    else $error("pll gate open while disabled");
  a_load_holds: assert property (fuseLoaded_q |=> fuseLoaded_q)
    else $error("fuse load flag dropped");
  // warm reset relocks only; option values must survive it
  a_warm_keeps: assert property (fuseLoaded_q && warmRstReq && !busWr |=>
    $stable({display_iface_enable, second_quad_port_enable}))
    else $error("warm reset changed options");
endmodule

/* test/ocb_option_bank_bench.sv */
`timescale 1ns/100ps
module ocb_option_bank_bench;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         warmRstReq = 1'b0;
  reg  [7:0]  busAddr = 8'h00;
  reg         busWr = 1'b0;
  reg         busRd = 1'b0;
  reg         busSuper = 1'b0;
  reg  [15:0] busWdata = 16'h0000;
  reg         fuseReady = 1'b0;
  reg         erased = 1'b1;
  reg  [5:0]  fuseCustMatch = 6'h00;
  reg         rtcDirReq = 1'b0;
  reg         lowVoltPin = 1'b0;
  reg         oscEnable = 1'b0;
  reg         slowOscTick = 1'b0;
  reg         pllEnable = 1'b0;
  reg         fastOscTick = 1'b0;
  reg  [15:0] rdv;
  reg         erv;
  integer     miscompares = 0;
  integer     numChecks = 0;
  wire        fuseCustErased = erased;
  wire        fuseOscErased = erased;
  wire        fuseRstfErased = erased;
  wire        fuseDetfErased = erased;
  wire        fuseAdcErased = erased;
  wire [11:0] fuseOscValue = 12'h123;
  wire [7:0]  fuseRstfValue = 8'h5A;
  wire        fuseDetfEnable = 1'b1;
  wire [7:0]  fuseDetfValue = 8'h77;
  wire [7:0]  fuseAdcValue = 8'hC3;
  wire [15:0] busRdata_q;
  wire        busErr_q;
  wire        display_iface_enable;
  wire        debug_prog_disable;
  wire        reset_out_pin_disable;
  wire        clock_out_pin_disable;
  wire        second_quad_port_enable;
  wire        detector_cfg_fuse_load;
  wire        rtcReconfigAllow_q;
  wire        rtcIsolate_q;
  wire [7:0]  adc_channel_disable_field;
  wire        oscGateOpen;
  wire        pllGateOpen;
  wire        fuseLoaded_q;
  wire [5:0]  pins = {display_iface_enable, debug_prog_disable, reset_out_pin_disable,
                      clock_out_pin_disable, second_quad_port_enable, detector_cfg_fuse_load};
  ocb_option_bank ocb_option_bank_i (
    .core_clk                  (core_clk),
    .rst_n                     (rst_n),
    .warmRstReq                (warmRstReq),
    .busAddr                   (busAddr),
    .busWr                     (busWr),
    .busRd                     (busRd),
    .busSuper                  (busSuper),
    .busWdata                  (busWdata),
    .busRdata_q                (busRdata_q),
    .busErr_q                  (busErr_q),
    .fuseReady                 (fuseReady),
    .fuseCustErased            (fuseCustErased),
    .fuseCustMatch             (fuseCustMatch),
    .fuseOscErased             (fuseOscErased),
    .fuseOscValue              (fuseOscValue),
    .fuseRstfErased            (fuseRstfErased),
    .fuseRstfValue             (fuseRstfValue),
    .fuseDetfErased            (fuseDetfErased),
    .fuseDetfEnable            (fuseDetfEnable),
    .fuseDetfValue             (fuseDetfValue),
    .fuseAdcErased             (fuseAdcErased),
    .fuseAdcValue              (fuseAdcValue),
    .rtcDirReq                 (rtcDirReq),
    .lowVoltPin                (lowVoltPin),
    .oscEnable                 (oscEnable),
    .slowOscTick               (slowOscTick),
    .pllEnable                 (pllEnable),
    .fastOscTick               (fastOscTick),
    .display_iface_enable      (display_iface_enable),
    .debug_prog_disable        (debug_prog_disable),
    .reset_out_pin_disable     (reset_out_pin_disable),
    .clock_out_pin_disable     (clock_out_pin_disable),
    .second_quad_port_enable   (second_quad_port_enable),
    .detector_cfg_fuse_load    (detector_cfg_fuse_load),
    .rtcReconfigAllow_q        (rtcReconfigAllow_q),
    .rtcIsolate_q              (rtcIsolate_q),
    .adc_channel_disable_field (adc_channel_disable_field),
    .oscGateOpen               (oscGateOpen),
    .pllGateOpen               (pllGateOpen),
    .fuseLoaded_q              (fuseLoaded_q)
  );
  always #4 core_clk = ~core_clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chkBit(input got, input exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %0t: flag got %b expected %b", $time, got, exp);
      end
    end
  endtask
  // request held until the taking edge, answer read in the cycle it stands
  task acc(input w, input s, input [7:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      #1;
      busWr = w;
      busRd = !w;
      busSuper = s;
      busAddr = a;
      busWdata = d;
      @(posedge core_clk);
      #1;
      busWr = 1'b0;
      busRd = 1'b0;
      rdv = busRdata_q;
      erv = busErr_q;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    acc(1'b1, 1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [15:0] exp);
    begin
      acc(1'b0, 1'b1, a, 16'h0000);
      chk(rdv, exp);
    end
  endtask
  task unlock(input [7:0] a);
    begin
      wr(a, 16'h4000);
      wr(a, 16'h8000);
      wr(a, 16'hC000);
    end
  endtask
  task por(input e, input [5:0] m);
    begin
      rst_n = 1'b0;
      fuseReady = 1'b0;
      erased = e;
      fuseCustMatch = m;
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1'b1;
      @(posedge core_clk);
      #1 fuseReady = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 chkBit(fuseLoaded_q, 1'b1);
    end
  endtask
  // tick period of 8 core cycles stays well under the sync limit
  task ticks(input sel, input integer n);
    integer k;
    begin
      for (k = 0; k < 2 * n; k = k + 1) begin
        repeat (4) @(posedge core_clk);
        #1;
        if (sel) fastOscTick = ~fastOscTick;
        else slowOscTick = ~slowOscTick;
      end
      repeat (8) @(posedge core_clk);
      #1;
    end
  endtask
  task t_fuse_gate;
    begin
      por(1'b0, 6'h00);
      rd(8'h20, 16'h03FF);
      rd(8'h26, 16'h0000);
      rd(8'h24, 16'h005A);
      chk({8'h00, adc_channel_disable_field}, 16'h0000);
      $display("fuse gate test done");
    end
  endtask
  task t_fuse_load;
    begin
      por(1'b0, 6'h3F);
      rd(8'h1E, 16'h039C);
      rd(8'h20, 16'h0123);
      rd(8'h26, 16'h0177);
      chk({8'h00, adc_channel_disable_field}, 16'h00C3);
      chk({10'h000, pins}, 16'h001D);
      $display("fuse load test done");
    end
  endtask
  task t_defaults;
    begin
      por(1'b1, 6'h3F);
      rd(8'h20, 16'h03FF);
      rd(8'h24, 16'h000D);
      rd(8'h26, 16'h0000);
      rd(8'h1E, 16'h0000);
      chk({10'h000, pins}, 16'h0000);
      $display("default test done");
    end
  endtask
  task t_unlock;
    begin
      rtcDirReq = 1'b1;
      lowVoltPin = 1'b1;
      wr(8'h1E, 16'h007F);
      rd(8'h1E, 16'h0000);
      unlock(8'h1E);
      wr(8'h1E, 16'hC07F);
      rd(8'h1E, 16'hC07F);
      repeat (4) @(posedge core_clk);
      #1;
      chk({10'h000, pins}, 16'h003E);
      chk({14'h0000, rtcReconfigAllow_q, rtcIsolate_q}, 16'h0002);
      wr(8'h1E, 16'h4000);
      rd(8'h1E, 16'hC000);
      wr(8'h1E, 16'h0041);
      rd(8'h1E, 16'h0041);
      repeat (4) @(posedge core_clk);
      #1;
      chk({14'h0000, rtcReconfigAllow_q, rtcIsolate_q}, 16'h0001);
      wr(8'h1E, 16'h4000);
      wr(8'h1E, 16'hC000);
      wr(8'h1E, 16'hC07F);
      rd(8'h1E, 16'h0041);
      rtcDirReq = 1'b0;
      lowVoltPin = 1'b0;
      $display("unlock test done");
    end
  endtask
  task t_pll;
    begin
      wr(8'h22, 16'hC005);
      rd(8'h22, 16'h0000);
      unlock(8'h22);
      wr(8'h22, 16'hC003);
      rd(8'h22, 16'hC003);
      wr(8'h22, 16'h0002);
      rd(8'h22, 16'hC003);
      unlock(8'h22);
      wr(8'h22, 16'h0004);
      pllEnable = 1'b1;
      ticks(1'b1, 3);
      chkBit(pllGateOpen, 1'b0);
      ticks(1'b1, 1);
      chkBit(pllGateOpen, 1'b1);
      pllEnable = 1'b0;
      $display("pll test done");
    end
  endtask
  task t_osc;
    begin
      unlock(8'h20);
      wr(8'h20, 16'h0003);
      rd(8'h20, 16'h0003);
      oscEnable = 1'b1;
      ticks(1'b0, 2);
      chkBit(oscGateOpen, 1'b0);
      ticks(1'b0, 1);
      chkBit(oscGateOpen, 1'b1);
      oscEnable = 1'b0;
      $display("osc test done");
    end
  endtask
  task t_user;
    begin
      acc(1'b1, 1'b0, 8'h24, 16'hFFFF);
      chkBit(erv, 1'b1);
      rd(8'h24, 16'h000D);
      acc(1'b0, 1'b0, 8'h24, 16'h0000);
      chkBit(erv, 1'b1);
      rd(8'h30, 16'h0000);
      chkBit(erv, 1'b0);
      $display("user test done");
    end
  endtask
  task t_warm;
    begin
      unlock(8'h24);
      wr(8'h24, 16'hC0AA);
      rd(8'h24, 16'hC0AA);
      warmRstReq = 1'b1;
      @(posedge core_clk);
      #1 warmRstReq = 1'b0;
      rd(8'h24, 16'h00AA);
      wr(8'h24, 16'h0055);
      rd(8'h24, 16'h00AA);
      chkBit(display_iface_enable, 1'b1);
      $display("warm test done");
    end
  endtask
  task t_detf;
    begin
      wr(8'h26, 16'h01FF);
      rd(8'h26, 16'h0000);
      unlock(8'h26);
      wr(8'h26, 16'hC1A5);
      rd(8'h26, 16'hC1A5);
      wr(8'h26, 16'h0033);
      rd(8'h26, 16'h0033);
      $display("detector filter test done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    t_fuse_gate;
    t_fuse_load;
    t_defaults;
    t_unlock;
    t_pll;
    t_osc;
    t_user;
    t_warm;
    t_detf;
    wrap_up;
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule
bind ocb_option_bank ocb_option_bank_props ocb_option_bank_props_i (
  .core_clk                (core_clk),
  .rst_n                   (rst_n),
  .warmRstReq              (warmRstReq),
  .busWr                   (busWr),
  .busRd                   (busRd),
  .busSuper                (busSuper),
  .busRdata_q              (busRdata_q),
  .busErr_q                (busErr_q),
  .rtcDirReq               (rtcDirReq),
  .rtcReconfigAllow_q      (rtcReconfigAllow_q),
  .lowVoltPin              (lowVoltPin),
  .rtcIsolate_q            (rtcIsolate_q),
  .oscEnable               (oscEnable),
  .oscGateOpen             (oscGateOpen),
  .pllEnable               (pllEnable),
  .pllGateOpen             (pllGateOpen),
  .fuseLoaded_q            (fuseLoaded_q),
  .display_iface_enable    (display_iface_enable),
  .second_quad_port_enable (second_quad_port_enable)
);
